// file: inc/ppd_pkg.sv
// Constants shared by the parallel port register block and its handshake unit.
// Assumes one 25 MHz clock and a bus master on that same clock.
// Operation
// - Handshake flag drives interrupt request low
// - Interrupt request releases once flag clears
// - Two mode bits per handshake line
// - Control A bit 2 enables input latch
// - Direction C sets bidirectional handshake direction
// - Plain A write always loads output latch
// - Output pins drive their latch bits
// - Unlatched A reads mix pins and latch
// - Handshake A writes leave latch alone
// - Reset keeps data latches unchanged
// - Plain and first B writes load latch
// - B reads mix pins and latch
// - A handshake access clears flag, read lowers line
// - B handshake access clears flag, write lowers line
// - Port C write always loads latch
// - Handshake C pins ignore port C data
// - C reads mix pins and latch
// - Strobe captures A once for all three A registers
// - Interrupt flag is enabled status OR
// - Modes 0,1 falling; 2,3 rising edge
// - Output mode 1 gives one-cycle low pulse
// - Warning read clears only buffered bit
package ppd_pkg;
    localparam int unsigned DW = 8;
    localparam int unsigned AW = 4;

    // Register offsets
    localparam logic [AW-1:0] OFF_A_HS1   = 4'h0;
    localparam logic [AW-1:0] OFF_A_HS2   = 4'h1;
    localparam logic [AW-1:0] OFF_A_PLAIN = 4'h2;
    localparam logic [AW-1:0] OFF_B_PLAIN = 4'h3;
    localparam logic [AW-1:0] OFF_C_PLAIN = 4'h4;
    localparam logic [AW-1:0] OFF_DIR_A   = 4'h6;
    localparam logic [AW-1:0] OFF_DIR_B   = 4'h7;
    localparam logic [AW-1:0] OFF_DIR_C   = 4'h8;
    localparam logic [AW-1:0] OFF_CTL_A   = 4'h9;
    localparam logic [AW-1:0] OFF_CTL_B   = 4'ha;
    localparam logic [AW-1:0] OFF_FSEL    = 4'hb;
    localparam logic [AW-1:0] OFF_B_HS1   = 4'hc;
    localparam logic [AW-1:0] OFF_B_HS2   = 4'hd;
    localparam logic [AW-1:0] OFF_HSTAT   = 4'he;
    localparam logic [AW-1:0] OFF_HWARN   = 4'hf;

    // Control register fields
    localparam int unsigned CR_STB_LO = 0;
    localparam int unsigned CR_LE_BIT = 2;
    localparam int unsigned CR_LN_LO  = 3;
    localparam int unsigned CR_LVL    = 4;
    localparam int unsigned MODE_RISE = 1;
    localparam int unsigned MODE_IRQ  = 0;
    localparam logic [DW-1:0] CTL_RST = 8'h00;

    // Port C handshake pin positions, also function select bits
    localparam int unsigned PIN_STB_A = 4;
    localparam int unsigned PIN_LN_A  = 5;
    localparam int unsigned PIN_STB_B = 6;
    localparam int unsigned PIN_LN_B  = 7;
    localparam logic [DW-1:0] STB_PINS = 8'h50;
    localparam logic [DW-1:0] LN_PINS  = 8'ha0;

    // Output line modes
    typedef enum logic [1:0] {
        PPD_OUT_HOLD  = 2'b00,
        PPD_OUT_PULSE = 2'b01,
        PPD_OUT_LOW   = 2'b10,
        PPD_OUT_HIGH  = 2'b11
    } ppd_mode_e;

    // Active edge per mode
    function automatic logic edgeHit(input logic [1:0] mode, input logic prev,
                                     input logic cur);
        return mode[MODE_RISE] ? (~prev & cur) : (prev & ~cur);
    endfunction : edgeHit

    // Output bits show latch, input bits show pins
    function automatic logic [DW-1:0] readMix(input logic [DW-1:0] dir,
                                              input logic [DW-1:0] lat,
                                              input logic [DW-1:0] pin);
        return (dir & lat) | (~dir & pin);
    endfunction : readMix
endpackage : ppd_pkg

// file: inc/ppd_hs_if.sv
// Signals between the register block and one handshake unit.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface ppd_hs_if;
    logic       strobeIn;
    logic       lineIn;
    logic [1:0] strobeMode;
    logic [1:0] lineMode;
    logic       lineLvl;
    logic       strobeSel;
    logic       lineSel;
    logic       lineIsOut;
    logic       acc1;
    logic       acc2;
    logic       lowReq;
    logic       warnRead;
    logic       strobeHit;
    logic       strobeFlag;
    logic       lineFlag;
    logic       strobeMissed;
    logic       lineMissed;
    logic       lineOut;

    modport ctl (output strobeIn, lineIn, strobeMode, lineMode, lineLvl, strobeSel,
                 lineSel, lineIsOut, acc1, acc2, lowReq, warnRead,
                 input strobeHit, strobeFlag, lineFlag, strobeMissed, lineMissed, lineOut);
    modport hs (input strobeIn, lineIn, strobeMode, lineMode, lineLvl, strobeSel,
                lineSel, lineIsOut, acc1, acc2, lowReq, warnRead,
                output strobeHit, strobeFlag, lineFlag, strobeMissed, lineMissed, lineOut);
endinterface : ppd_hs_if
`default_nettype wire

// file: core/ppd_handshake.sv
// One port's handshake pair: strobe input and bidirectional line.
// Assumes synchronised pin levels and one-cycle access pulses.
`timescale 1ns/1ps
`default_nettype none
module ppd_handshake
    import ppd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    ppd_hs_if.hs     hs
);
    logic stbPrev_q;
    logic lnPrev_q;
    logic stbFlag_q;
    logic lnFlag_q;
    logic stbMiss_q;
    logic lnMiss_q;
    logic stbBuf_q;
    logic lnBuf_q;
    logic lineOut_q;

    // ==========================================================
    // Edge detection
    // edge per mode
    wire logic stbAct = hs.strobeSel & edgeHit(hs.strobeMode, stbPrev_q, hs.strobeIn);
    wire logic lnAct  = hs.lineSel & ~hs.lineIsOut
                        & edgeHit(hs.lineMode, lnPrev_q, hs.lineIn);

    // History of levels, data only so no reset needed
    always_ff @(posedge clk_sys) begin
        stbPrev_q <= hs.strobeIn;
        lnPrev_q  <= hs.lineIn;
    end

    // ==========================================================
    // Status, warning and buffer latch; a new edge beats a clear
    // access clears flag
    wire logic stbFlag_d = stbAct | (stbFlag_q & ~hs.acc1);
    wire logic lnFlag_d  = lnAct | (lnFlag_q & ~hs.acc2);
    wire logic stbMiss_d = (stbAct & stbFlag_q) | (stbMiss_q & ~(hs.warnRead & stbBuf_q));
    wire logic lnMiss_d  = (lnAct & lnFlag_q) | (lnMiss_q & ~(hs.warnRead & lnBuf_q));
    wire logic stbBuf_d  = hs.acc1 ? stbMiss_q : (stbBuf_q & ~hs.warnRead);
    wire logic lnBuf_d   = hs.acc2 ? lnMiss_q : (lnBuf_q & ~hs.warnRead);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            {stbFlag_q, lnFlag_q, stbMiss_q, lnMiss_q} <= 4'h0;
            {stbBuf_q, lnBuf_q} <= 2'h0;
        end else begin
            {stbFlag_q, lnFlag_q, stbMiss_q, lnMiss_q} <= {stbFlag_d, lnFlag_d,
                                                          stbMiss_d, lnMiss_d};
            {stbBuf_q, lnBuf_q} <= {stbBuf_d, lnBuf_d};
        end
    end

    // ==========================================================
    // Output line level
    // pulse one cycle
    wire logic lineOut_d = hs.lineMode[MODE_RISE] ? hs.lineLvl
                         : hs.lowReq ? 1'b0
                         : (hs.lineMode == PPD_OUT_HOLD) ? (lineOut_q | stbAct)
                         : 1'b1;

    // Default level high for the two handshake modes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lineOut_q <= 1'b1;
        end else begin
            lineOut_q <= lineOut_d;
        end
    end

    assign hs.strobeHit    = stbAct;
    assign hs.strobeFlag   = stbFlag_q;
    assign hs.lineFlag     = lnFlag_q;
    assign hs.strobeMissed = stbMiss_q;
    assign hs.lineMissed   = lnMiss_q;
    assign hs.lineOut      = lineOut_q;

    // ==========================================================
    // Checks
    AST_FLAG_CLEAR: assert property (@(posedge clk_sys) disable iff (srst)
        hs.acc1 && !stbAct |=> !stbFlag_q)
        else $error("strobe flag not cleared by access");
    AST_EDGE_SETS: assert property (@(posedge clk_sys) disable iff (srst)
        hs.strobeSel && !hs.strobeMode[MODE_RISE] && $fell(hs.strobeIn) |=> stbFlag_q)
        else $error("falling strobe did not set flag");
    AST_PULSE_WIDTH: assert property (@(posedge clk_sys) disable iff (srst)
        hs.lineMode == PPD_OUT_PULSE && hs.lowReq
        ##1 hs.lineMode == PPD_OUT_PULSE && !hs.lowReq
        |-> !lineOut_q ##1 lineOut_q)
        else $error("mode 1 pulse not one cycle");
    AST_WARN_KEEP: assert property (@(posedge clk_sys) disable iff (srst)
        hs.warnRead && !lnBuf_q && lnMiss_q |=> lnMiss_q)
        else $error("unbuffered warning bit cleared");
endmodule : ppd_handshake
`default_nettype wire

// file: core/ppd_port_regs.sv
// Three-port parallel interface registers with handshake and interrupt.
// Assumes a bus master on clk_sys giving one-cycle address and data strobes.
`timescale 1ns/1ps
`default_nettype none
module ppd_port_regs
    import ppd_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          srst,
    input  wire logic          busAs,
    input  wire logic          busDs,
    input  wire logic          busRw,
    input  wire logic          busCsN,
    input  wire logic [DW-1:0] adIn,
    output var  logic [DW-1:0] adOut,
    output var  logic          adOe,
    input  wire logic [DW-1:0] paIn,
    output var  logic [DW-1:0] paOut,
    output var  logic [DW-1:0] paOe,
    input  wire logic [DW-1:0] pbIn,
    output var  logic [DW-1:0] pbOut,
    output var  logic [DW-1:0] pbOe,
    input  wire logic [DW-1:0] pcIn,
    output var  logic [DW-1:0] pcOut,
    output var  logic [DW-1:0] pcOe,
    output var  logic          irqN
);
    logic [AW-1:0] addr_q;
    logic [DW-1:0] paS1_q, paS2_q;
    logic [DW-1:0] pbS1_q, pbS2_q;
    logic [DW-1:0] pcS1_q, pcS2_q;
    logic [DW-1:0] dirA_q, dirB_q, dirC_q;
    logic [DW-1:0] ctlA_q, ctlB_q, fsel_q;
    logic [DW-1:0] outA_q, outB_q, outC_q;
    logic [DW-1:0] latA_q;
    logic [DW-1:0] adOut_q;
    logic          adOe_q;
    logic [DW-1:0] pcOut_q, pcOe_q;
    logic          irqN_q;

    ppd_hs_if hsA ();
    ppd_hs_if hsB ();

    // ==========================================================
    // Pin synchronisers; second stage is the only reader of the first
    always_ff @(posedge clk_sys) begin
        paS1_q <= paIn;
        paS2_q <= paS1_q;
        pbS1_q <= pbIn;
        pbS2_q <= pbS1_q;
        pcS1_q <= pcIn;
        pcS2_q <= pcS1_q;
    end

    // ==========================================================
    // Bus decode
    wire logic selOk = busDs & ~busCsN;
    wire logic wrEn  = selOk & ~busRw;
    wire logic rdEn  = selOk & busRw;
    wire logic accEn = selOk;
    wire logic hitA1 = addr_q == OFF_A_HS1;
    wire logic hitA2 = addr_q == OFF_A_HS2;
    wire logic hitAP = addr_q == OFF_A_PLAIN;
    wire logic hitBP = addr_q == OFF_B_PLAIN;
    wire logic hitCP = addr_q == OFF_C_PLAIN;
    wire logic hitB1 = addr_q == OFF_B_HS1;
    wire logic hitB2 = addr_q == OFF_B_HS2;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            addr_q <= OFF_A_HS1;
        end else if (busAs && !busCsN) begin
            addr_q <= adIn[AW-1:0];
        end
    end

    // ==========================================================
    // Control registers, cleared by reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dirA_q <= CTL_RST;
            dirB_q <= CTL_RST;
            dirC_q <= CTL_RST;
            ctlA_q <= CTL_RST;
            ctlB_q <= CTL_RST;
            fsel_q <= CTL_RST;
        end else if (wrEn) begin
            if (addr_q == OFF_DIR_A) dirA_q <= adIn;
            if (addr_q == OFF_DIR_B) dirB_q <= adIn;
            if (addr_q == OFF_DIR_C) dirC_q <= adIn;
            if (addr_q == OFF_CTL_A) ctlA_q <= adIn;
            if (addr_q == OFF_CTL_B) ctlB_q <= adIn;
            if (addr_q == OFF_FSEL)  fsel_q <= adIn;
        end
    end

    // ==========================================================
    // Output data latches; no reset so contents survive it
    // latches not reset
    always_ff @(posedge clk_sys) begin
        if (wrEn && hitAP) outA_q <= adIn;
        if (wrEn && (hitBP || hitB1)) outB_q <= adIn;
        if (wrEn && hitCP) outC_q <= adIn;
    end

    // ==========================================================
    // Strobe input latch for port A
    // latch enable bit
    wire logic latchOn = ctlA_q[CR_LE_BIT];
    wire logic latchGo = latchOn & hsA.strobeHit & ~hsA.strobeFlag;
    wire logic latchHeld = latchOn & hsA.strobeFlag;

    // One capture serves all three port A data registers
    always_ff @(posedge clk_sys) begin
        if (latchGo) latA_q <= paS2_q;
    end

    // ==========================================================
    // Handshake units
    // two-bit mode fields
    assign hsA.strobeMode = ctlA_q[CR_STB_LO +: 2];
    assign hsA.lineMode   = ctlA_q[CR_LN_LO +: 2];
    assign hsB.strobeMode = ctlB_q[CR_STB_LO +: 2];
    assign hsB.lineMode   = ctlB_q[CR_LN_LO +: 2];
    assign hsA.lineLvl    = ctlA_q[CR_LVL];
    assign hsB.lineLvl    = ctlB_q[CR_LVL];
    assign hsA.strobeIn   = pcS2_q[PIN_STB_A];
    assign hsA.lineIn     = pcS2_q[PIN_LN_A];
    assign hsB.strobeIn   = pcS2_q[PIN_STB_B];
    assign hsB.lineIn     = pcS2_q[PIN_LN_B];
    assign hsA.strobeSel  = fsel_q[PIN_STB_A];
    assign hsA.lineSel    = fsel_q[PIN_LN_A];
    assign hsB.strobeSel  = fsel_q[PIN_STB_B];
    assign hsB.lineSel    = fsel_q[PIN_LN_B];
    assign hsA.lineIsOut  = dirC_q[PIN_LN_A];
    assign hsB.lineIsOut  = dirC_q[PIN_LN_B];

    assign hsA.acc1   = accEn & hitA1;
    assign hsA.acc2   = accEn & hitA2;
    // Port A lowers its line on reads, the preferred input port
    assign hsA.lowReq = rdEn & (hitA1 | (hitA2 & ~hsA.strobeFlag));
    assign hsB.acc1   = accEn & hitB1;
    assign hsB.acc2   = accEn & hitB2;
    // Port B lowers its line on writes, the preferred output port
    assign hsB.lowReq = wrEn & (hitB1 | (hitB2 & ~hsB.strobeFlag));
    assign hsA.warnRead = rdEn & (addr_q == OFF_HWARN);
    assign hsB.warnRead = rdEn & (addr_q == OFF_HWARN);

    ppd_handshake uHsA (
        .clk_sys (clk_sys),
        .srst    (srst),
        .hs      (hsA.hs)
    );

    ppd_handshake uHsB (
        .clk_sys (clk_sys),
        .srst    (srst),
        .hs      (hsB.hs)
    );

    // ==========================================================
    // Status words
    wire logic [3:0] hsFlags = {hsB.lineFlag, hsA.lineFlag, hsB.strobeFlag, hsA.strobeFlag};
    wire logic [3:0] hsEna   = {ctlB_q[CR_LN_LO + MODE_IRQ], ctlA_q[CR_LN_LO + MODE_IRQ],
                                ctlB_q[CR_STB_LO + MODE_IRQ], ctlA_q[CR_STB_LO + MODE_IRQ]};
    wire logic irqFlag = |(hsFlags & hsEna);
    wire logic [DW-1:0] statWord = {irqFlag, 3'h0, hsFlags};
    wire logic [DW-1:0] warnWord = {4'h0, hsB.lineMissed, hsA.lineMissed,
                                    hsB.strobeMissed, hsA.strobeMissed};

    // ==========================================================
    // Read data selection
    // mix or captured
    wire logic [DW-1:0] pinA  = latchHeld ? latA_q : paS2_q;
    wire logic [DW-1:0] rdA   = readMix(dirA_q, outA_q, pinA);
    wire logic [DW-1:0] rdB   = readMix(dirB_q, outB_q, pbS2_q);
    wire logic [DW-1:0] rdC   = readMix(dirC_q, outC_q, pcS2_q);
    wire logic [DW-1:0] rdMux =
        (hitA1 || hitA2 || hitAP) ? rdA :
        (hitBP || hitB1 || hitB2) ? rdB :
        hitCP                     ? rdC :
        (addr_q == OFF_DIR_A)     ? dirA_q :
        (addr_q == OFF_DIR_B)     ? dirB_q :
        (addr_q == OFF_DIR_C)     ? dirC_q :
        (addr_q == OFF_CTL_A)     ? ctlA_q :
        (addr_q == OFF_CTL_B)     ? ctlB_q :
        (addr_q == OFF_FSEL)      ? fsel_q :
        (addr_q == OFF_HSTAT)     ? statWord :
        (addr_q == OFF_HWARN)     ? warnWord :
                                    CTL_RST;

    // Read answer stands one cycle after the data strobe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            adOut_q <= CTL_RST;
            adOe_q  <= 1'b0;
        end else begin
            adOut_q <= rdEn ? rdMux : adOut_q;
            adOe_q  <= rdEn;
        end
    end

    // ==========================================================
    // Port C drive; handshake pins override the data latch
    // handshake pins excluded
    wire logic [DW-1:0] hsMask  = fsel_q & (STB_PINS | LN_PINS);
    wire logic [DW-1:0] hsLevel = {hsB.lineOut, 1'b0, hsA.lineOut, 5'h00} & LN_PINS;
    wire logic [DW-1:0] pcOut_d = (outC_q & ~hsMask) | (hsLevel & hsMask);
    wire logic [DW-1:0] pcOe_d  = dirC_q & ~(fsel_q & STB_PINS);

    // Registered so that pin outputs come from flops
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pcOut_q <= CTL_RST;
            pcOe_q  <= CTL_RST;
        end else begin
            pcOut_q <= pcOut_d;
            pcOe_q  <= pcOe_d;
        end
    end

    // ==========================================================
    // Interrupt request, one cycle behind the flag
    // drive low
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irqN_q <= 1'b1;
        end else begin
            irqN_q <= ~irqFlag;
        end
    end

    // ==========================================================
    // Outputs
    // pins follow latch
    assign paOut = outA_q;
    assign paOe  = dirA_q;
    assign pbOut = outB_q;
    assign pbOe  = dirB_q;
    assign pcOut = pcOut_q;
    assign pcOe  = pcOe_q;
    assign adOut = adOut_q;
    assign adOe  = adOe_q;
    assign irqN  = irqN_q;

    // ==========================================================
    // Checks
    AST_IRQ_LOW: assert property (@(posedge clk_sys) disable iff (srst)
        irqFlag |=> !irqN)
        else $error("interrupt not asserted");

    AST_IRQ_RELEASE: assert property (@(posedge clk_sys) disable iff (srst)
        $fell(irqFlag) |-> ##1 irqN)
        else $error("interrupt not released");

    AST_IRQ_QUIET: assert property (@(posedge clk_sys) disable iff (srst)
        (hsFlags & hsEna) == 4'h0
        |=> irqN)
        else $error("interrupt from disabled line");

    // Bus and latch checks
    AST_ADDR_LATCH: assert property (@(posedge clk_sys) disable iff (srst)
        busAs && !busCsN
        |=> addr_q == $past(adIn[AW-1:0]))
        else $error("register address not latched");

    AST_A_PLAIN_WR: assert property (@(posedge clk_sys) disable iff (srst)
        wrEn && hitAP |=> paOut == $past(adIn))
        else $error("plain A write lost");

    AST_A_HS_WR: assert property (@(posedge clk_sys) disable iff (srst)
        wrEn && (hitA1 || hitA2) |=> $stable(paOut))
        else $error("handshake A write changed latch");

    AST_B_LOAD: assert property (@(posedge clk_sys) disable iff (srst)
        wrEn && (hitBP || hitB1)
        |=> pbOut == $past(adIn))
        else $error("port B write lost");

    AST_B_HS2_WR: assert property (@(posedge clk_sys) disable iff (srst)
        wrEn && hitB2 |=> $stable(pbOut))
        else $error("second B write changed latch");

    AST_C_WR: assert property (@(posedge clk_sys) disable iff (srst)
        wrEn && hitCP
        |=> outC_q == $past(adIn))
        else $error("port C write lost");

    // Port C pin checks
    AST_C_HS_PIN: assert property (@(posedge clk_sys) disable iff (srst)
        fsel_q[PIN_STB_A] && $stable(fsel_q) |=> !pcOe[PIN_STB_A])
        else $error("strobe pin driven");

    AST_LINE_DIR: assert property (@(posedge clk_sys) disable iff (srst)
        dirC_q[PIN_LN_A]
        |=> pcOe[PIN_LN_A])
        else $error("line A direction ignored");

    // Read and capture checks
    AST_A_CAPTURE: assert property (@(posedge clk_sys) disable iff (srst)
        latchHeld && rdEn && (hitA1 || hitA2 || hitAP) |=> adOut == readMix(
            $past(dirA_q), $past(outA_q), $past(latA_q)))
        else $error("captured A data not returned");

    AST_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
        latchHeld
        |=> $stable(latA_q))
        else $error("captured A data overwritten");

    AST_RD_A_LIVE: assert property (@(posedge clk_sys) disable iff (srst)
        rdEn && (hitA1 || hitA2 || hitAP) && !latchOn
        |=> adOut == readMix($past(dirA_q), $past(outA_q), $past(paS2_q)))
        else $error("port A live read wrong");

    AST_RD_B: assert property (@(posedge clk_sys) disable iff (srst)
        rdEn && (hitBP || hitB1 || hitB2) |=> adOe && adOut == readMix(
            $past(dirB_q), $past(outB_q), $past(pbS2_q)))
        else $error("port B read wrong");

    AST_RD_C: assert property (@(posedge clk_sys) disable iff (srst)
        rdEn && hitCP
        |=> adOut == readMix($past(dirC_q), $past(outC_q), $past(pcS2_q)))
        else $error("port C read wrong");

    // Handshake line checks
    AST_A_LINE_LOW: assert property (@(posedge clk_sys) disable iff (srst)
        ctlA_q[CR_LN_LO +: 2] == PPD_OUT_HOLD && rdEn && hitA1
        |=> !hsA.lineOut)
        else $error("port A line not lowered");

    AST_B_LINE_LOW: assert property (@(posedge clk_sys) disable iff (srst)
        ctlB_q[CR_LN_LO +: 2] == PPD_OUT_HOLD && wrEn && hitB1
        |=> !hsB.lineOut)
        else $error("port B line not lowered");
endmodule : ppd_port_regs
`default_nettype wire

// file: bench/ppd_cpu_model.sv
// Bus master model: address phase, then one data phase per access.
// Assumes the register block samples the bus on rising clk_sys edges.
`timescale 1ns/1ps
`default_nettype none
module ppd_cpu_model
    import ppd_pkg::*;
(
    input  wire logic          clk_sys,
    output var  logic          busAs,
    output var  logic          busDs,
    output var  logic          busRw,
    output var  logic          busCsN,
    output var  logic [DW-1:0] adIn
);
    // ==========================================
    // Idle bus
    initial begin
        busAs  = 1'b0;
        busDs  = 1'b0;
        busRw  = 1'b1;
        busCsN = 1'b1;
        adIn   = 8'h00;
    end

    task automatic acc(input logic [AW-1:0] a, input logic rw, input logic [DW-1:0] d);
        @(posedge clk_sys);
        #1;
        busAs  = 1'b1;
        busCsN = 1'b0;
        adIn   = {4'h0, a};
        @(posedge clk_sys);
        #1;
        busAs = 1'b0;
        busDs = 1'b1;
        busRw = rw;
        adIn  = d;
        @(posedge clk_sys);
        #1;
        busDs  = 1'b0;
        busCsN = 1'b1;
        adIn   = ~d; // Released bus never keeps last value
    endtask : acc
endmodule : ppd_cpu_model
`default_nettype wire

// file: bench/parallel_port_data_regs_bench.sv
// Bench for the parallel port registers: latches, pins, handshake, interrupt.
// Assumes the bus model drives the bus; pins are driven here.
`timescale 1ns/1ps
`default_nettype none
module parallel_port_data_regs_bench
    import ppd_pkg::*;
;
    logic          clk_sys = 1'b0;
    logic          srst, busAs, busDs, busRw, busCsN, adOe, irqN;
    logic [DW-1:0] adIn, adOut, paIn, paOut, paOe, pbIn, pbOut, pbOe, pcIn, pcOut, pcOe;
    logic [DW-1:0] expQ[$];
    logic [DW-1:0] v, w, b, c;
    logic [31:0]   seed = 32'h3de5;
    int            fails = 0;
    int            checks = 0;

    // ==========================================
    // Clock and instances
    always #20 clk_sys = ~clk_sys;
    ppd_port_regs dut_u (.clk_sys, .srst, .busAs, .busDs, .busRw, .busCsN, .adIn, .adOut,
        .adOe, .paIn, .paOut, .paOe, .pbIn, .pbOut, .pbOe, .pcIn, .pcOut, .pcOe, .irqN);
    ppd_cpu_model cpu_u (.clk_sys, .busAs, .busDs, .busRw, .busCsN, .adIn);

    // ==========================================
    // Helpers
    function automatic logic [DW-1:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd

    task automatic end_sim();
        if (expQ.size() != 0) fails++; // Reads that never answered
        $display("Checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] want);
        checks++;
        if (got !== want) begin
            $display("Error %0t: got %h want %h", $time, got, want);
            fails++;
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        cpu_u.acc(a, 1'b0, d);
    endtask : wr

    // Expectation queued before the bus cycle starts
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
        expQ.push_back(e);
        cpu_u.acc(a, 1'b1, rnd());
    endtask : rd

    // Pins pass a two-flop synchroniser first
    task automatic settle();
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic waitIrq(input logic lvl);
        for (int i = 0; i < 12 && irqN !== lvl; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk({7'h0, irqN}, {7'h0, lvl});
        if (irqN !== lvl) end_sim();
    endtask : waitIrq

    task automatic lowCount(input int idx, input logic [DW-1:0] want);
        logic [DW-1:0] n;
        n = 8'h00;
        repeat (8) begin
            @(posedge clk_sys);
            #1;
            n += {7'h0, ~pcOut[idx]};
        end
        chk(n, want);
    endtask : lowCount

    // ==========================================
    // Read monitor: oldest note against each answer
    always @(posedge clk_sys) begin
        if (adOe === 1'b1) begin
            checks++;
            if (expQ.size() == 0 || adOut !== expQ[0]) begin
                $display("Error %0t: read data %h unexpected", $time, adOut);
                fails++;
            end
            if (expQ.size() != 0) void'(expQ.pop_front());
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        srst = 1'b1;
        paIn = 8'h00;
        pbIn = 8'h00;
        pcIn = 8'h50; // Strobe pins idle high
        repeat (10) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        v = rnd();
        w = rnd();
        b = rnd();
        c = rnd();
        wr(OFF_A_PLAIN, v);
        wr(OFF_DIR_A, 8'h0f);
        wr(OFF_A_HS1, ~v);
        chk(paOut, v);
        chk(paOe, 8'h0f);
        paIn = w;
        settle();
        rd(OFF_A_PLAIN, (v & 8'h0f) | (w & 8'hf0));
        rd(OFF_A_HS2, (v & 8'h0f) | (w & 8'hf0));
        wr(OFF_B_HS1, b);
        wr(OFF_B_HS2, ~b);
        wr(OFF_DIR_B, 8'h3c);
        pbIn = w;
        settle();
        chk(pbOut, b);
        rd(OFF_B_HS2, (b & 8'h3c) | (w & 8'hc3));
        wr(OFF_C_PLAIN, c);
        wr(OFF_DIR_C, 8'hf3);
        pcIn = w | 8'h50;
        settle();
        rd(OFF_C_PLAIN, (c & 8'hf3) | (w & 8'h0c));
        rd(4'h5, 8'h00);
        wr(OFF_FSEL, 8'hf0);
        settle();
        chk(pcOe, 8'ha3);
        chk(pcOut, c & 8'h0f);
        // Strobe A falling edge, mode 1
        wr(OFF_CTL_A, 8'h01);
        pcIn[PIN_STB_A] = 1'b0;
        waitIrq(1'b0);
        rd(OFF_HSTAT, 8'h81);
        rd(OFF_A_HS1, (v & 8'h0f) | (w & 8'hf0));
        waitIrq(1'b1);
        settle();
        chk({7'h0, pcOut[PIN_LN_A]}, 8'h00);
        // Rising edge, mode 3, with input capture
        wr(OFF_DIR_A, 8'h00);
        wr(OFF_CTL_A, 8'h07);
        pcIn[PIN_STB_A] = 1'b1;
        waitIrq(1'b0);
        paIn = ~w;
        settle();
        rd(OFF_A_PLAIN, w);
        pcIn[PIN_STB_A] = 1'b0;
        settle();
        pcIn[PIN_STB_A] = 1'b1;
        settle();
        rd(OFF_HWARN, 8'h01);
        rd(OFF_A_HS1, w);
        rd(OFF_HWARN, 8'h01);
        rd(OFF_HWARN, 8'h00);
        rd(OFF_A_HS2, ~w);
        waitIrq(1'b1);
        // Line B pulse mode after a write
        wr(OFF_CTL_B, 8'h08);
        wr(OFF_B_HS1, b);
        lowCount(PIN_LN_B, 8'h01);
        srst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        chk(paOut, v);
        chk(pbOut, b);
        chk(pbOe, 8'h00);
        end_sim();
    end
endmodule : parallel_port_data_regs_bench
`default_nettype wire
